// ---- dv/poc_chk.sv ----
`timescale 1ns/1ns
module poc_chk #(
  parameter int RETARD = 200,
  parameter int RST_MAX = 300
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire poc_pkg::poc_bus_t bus,
  input wire logic [31:0] rdata,
  input wire poc_pkg::poc_meas_t meas,
  input wire logic tick,
  input wire logic [7:0] di,
  input wire logic [7:0] vi,
  input wire logic [3:0] lgc,
  input wire logic [poc_pkg::NRLY-1:0] relay,
  input wire logic [poc_pkg::NLED-1:0] led,
  input wire logic [poc_pkg::NSTG-1:0] start,
  input wire logic [poc_pkg::NSTG-1:0] trip,
  input wire poc_pkg::poc_stg_e_t [poc_pkg::NSTG-1:0] status
);
  import poc_pkg::*;
  logic [31:0] quiet;
  logic [31:0] next_quiet;
  // cycles since the last measurement tick
  always_comb begin
    next_quiet = tick ? 32'h0000_0000 : quiet + 32'h0000_0001;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      quiet <= 32'h0000_0000;
    end else begin
      quiet <= next_quiet;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_read_data_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  a_reset_outputs_clear: assert property ($rose(arst_n) |-> start == '0 && trip == '0
    && relay == '0 && led == '0) else $error("outputs not clear after reset");
  a_relay_has_cause: assert property (|relay |-> $past(|{start, trip}))
    else $error("relay set without a stage signal");
  a_led_has_cause: assert property (|led |-> $past(|{start, trip}))
    else $error("indicator set without a stage signal");
  a_trip_shows_state: assert property ($rose(trip[0]) |-> ##[0:2] status[0] == STG_TRIP)
    else $error("trip without trip state");
  a_blocked_no_trip: assert property (status[0] == STG_BLOCKED |-> !trip[0] ##1 !trip[0])
    else $error("blocked stage trips");
  a_trip_on_tick: assert property ($rose(trip[0]) |->
    $past(tick) || $past(tick, 2) || $past(tick, 3)) else $error("trip without a tick");
  a_stale_release: assert property (quiet > RETARD + RST_MAX + 8 |-> start == '0)
    else $error("start held without measurements");
endmodule : poc_chk

// ---- dv/poc_far.sv ----
`timescale 1ns/1ns
module poc_far (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] raise,
  input wire logic [6:0] noise,
  input wire logic [poc_pkg::NRLY-1:0] relay,
  output logic [7:0] di,
  output logic [7:0] vi,
  output logic [3:0] lgc,
  output logic [31:0] trips
);
  import poc_pkg::*;
  logic prev_r;
  // blocking sources and relay contact watcher
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {di, vi, lgc, trips, prev_r} <= '0;
    end else begin
      di <= {noise, raise[0]};
      vi <= {noise, raise[1]};
      lgc <= {noise[2:0], raise[2]};
      trips <= trips + {31'h0, relay[0] & !prev_r};
      prev_r <= relay[0];
    end
  end
endmodule : poc_far

// ---- dv/tb.sv ----
`timescale 1ns/1ns
module tb;
  import poc_pkg::*;
  localparam int RTD = 200;
  localparam int RMX = 300;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  poc_bus_t bus = '0;
  poc_meas_t meas;
  logic tick = 1'b0;
  logic [31:0] rdata;
  logic [7:0] di, vi;
  logic [3:0] lgc;
  logic [NRLY-1:0] relay;
  logic [NLED-1:0] led;
  logic [NSTG-1:0] start, trip;
  poc_stg_e_t [NSTG-1:0] status;
  logic [2:0] raise = '0;
  logic [6:0] noise = '0;
  logic [31:0] trips;
  logic [31:0] lf = 32'h0000_2A6A;
  logic [31:0] expq [$];
  logic pend = 1'b0;
  int bad_count = 0;
  int n_tests = 0;
  always #2 clk = ~clk;
  poc_relay #(.RETARD(RTD), .RST_MAX(RMX)) u_dut (.clk, .arst_n, .bus, .rdata, .meas,
    .tick, .di, .vi, .lgc, .relay, .led, .start, .trip, .status);
  poc_far u_far (.clk, .arst_n, .raise, .noise, .relay, .di, .vi, .lgc, .trips);
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      bad_count++;
      $display("Error at %0t: seen %h want %h", $time, seen, want);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    expq.push_back(e);
    @(posedge clk);
    bus.rd <= 1'b0;
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic ph(input logic [15:0] v);
    meas.il2 <= v;
  endtask : ph
  task automatic note(input string s);
    $display("test done: %s", s);
  endtask : note
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  // read data checked one cycle after each read strobe
  always @(posedge clk) begin
    if (pend) begin
      chk(rdata, expq.pop_front());
    end
    pend <= bus.rd;
  end
  // random noise on the quiet phases and unused source bits
  always @(posedge clk) begin
    lf <= nx(lf);
    meas.il1 <= {9'h000, lf[6:0]};
    meas.il3 <= {9'h000, lf[14:8]};
    noise <= lf[22:16];
  end
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
  initial begin
    meas = '0;
    meas.freq = 16'hFFFF;
    cyc(4);
    arst_n <= 1'b1;
    tick <= 1'b1;
    rd(OFS_MODE, 32'h0);
    rd(OFS_CTRL, RST_CTRL);
    rd(OFS_SET, RST_SET);
    rd(OFS_AUX, {16'h0000, RST_AUX});
    rd(8'h1C, 32'h0);
    rd(OFS_STATE, 32'h0);
    note("reset values");
    wr(OFS_RLY, 32'h40);
    wr(OFS_LED, 32'h41);
    wr(OFS_SET, 32'h0014_0100);
    ph(16'h0180);
    cyc(8);
    rd(OFS_STATE, 32'h1);
    ph(16'h0000);
    cyc(40);
    rd(OFS_STATE, 32'h0);
    chk(trips, 32'h0);
    ph(16'h0180);
    cyc(40);
    rd(OFS_STATE, 32'h3);
    ph(16'h0000);
    cyc(40);
    rd(OFS_STATE, 32'h0);
    note("definite delay");
    wr(OFS_SET, 32'h0000_0100);
    ph(16'h0180);
    cyc(6);
    rd(OFS_STATE, 32'h3);
    ph(16'h00FE);
    cyc(30);
    rd(OFS_STATE, 32'h3);
    ph(16'h00F0);
    cyc(30);
    rd(OFS_STATE, 32'h0);
    note("instant and hysteresis");
    wr(OFS_CTRL, 32'h0000_013F);
    ph(16'h0180);
    cyc(6);
    ph(16'h0000);
    cyc(30);
    rd(OFS_STATE, 32'h3);
    chk({31'h0, relay[0]}, 32'h1);
    chk({31'h0, led[0]}, 32'h1);
    wr(OFS_LCLR, 32'h0);
    rd(OFS_STATE, 32'h0);
    wr(OFS_CTRL, 32'h0001_003F);
    wr(OFS_SET, 32'h0001_0100);
    ph(16'h0180);
    cyc(4);
    rd(OFS_STATE, 32'h3);
    ph(16'h0000);
    cyc(30);
    ph(16'h0110);
    cyc(4);
    rd(OFS_STATE, 32'h1);
    ph(16'h0000);
    cyc(30);
    chk({24'h0, led}, 32'h0);
    wr(OFS_CTRL, RST_CTRL);
    note("latch and inverse delay");
    wr(OFS_BLK, 32'h0001_0101);
    for (int k = 0; k < 3; k++) begin
      raise <= 3'b001 << k;
      cyc(2);
      ph(16'h0180);
      cyc(6);
      rd(OFS_STATE, 32'h2);
      ph(16'h0000);
      raise <= 3'b000;
      cyc(20);
    end
    wr(OFS_SET, 32'h0014_0100);
    ph(16'h0180);
    cyc(10);
    raise <= 3'b010;
    cyc(50);
    rd(OFS_STATE, 32'h2);
    raise <= 3'b000;
    cyc(4);
    rd(OFS_STATE, 32'h1);
    cyc(10);
    rd(OFS_STATE, 32'h3);
    raise <= 3'b100;
    cyc(10);
    rd(OFS_STATE, 32'h3);
    ph(16'h0000);
    raise <= 3'b000;
    cyc(40);
    rd(OFS_STATE, 32'h0);
    chk(trips, 32'h5);
    note("blocking");
    wr(OFS_UV, 32'h0000_0100);
    wr(OFS_SET + 8'h0C, 32'h0000_1000);
    meas.freq <= 16'h0800;
    cyc(6);
    rd(OFS_STATE, 32'h80);
    meas.volt <= 16'h0200;
    cyc(6);
    rd(OFS_STATE, 32'hC0);
    meas.freq <= 16'hFFFF;
    cyc(30);
    rd(OFS_STATE, 32'h0);
    note("under-voltage block");
    wr(OFS_SET + 8'h10, 32'h0000_0100);
    meas.i2 <= 16'h0300;
    cyc(6);
    rd(OFS_STATE, 32'h0);
    wr(OFS_MODE, 32'h1);
    rd(OFS_STATUS, 32'h4);
    wr(OFS_STATUS, 32'h4);
    wr(OFS_KEY, CONFIGURATION_MENU_KEY);
    wr(OFS_MODE, 32'h1);
    rd(OFS_STATUS, 32'h1);
    wr(OFS_INOM_M, 32'h200);
    wr(OFS_SET, 32'h0000_0100);
    ph(16'h0180);
    cyc(10);
    rd(OFS_STATE, 32'h300);
    ph(16'h0280);
    cyc(10);
    rd(OFS_STATE, 32'h303);
    tick <= 1'b0;
    cyc(RTD + RMX + 40);
    rd(OFS_STATE, 32'h0);
    tick <= 1'b1;
    ph(16'h0000);
    meas.i2 <= 16'h0000;
    cyc(40);
    wr(OFS_KEY, 32'h0);
    wr(OFS_MODE, 32'h0);
    rd(OFS_STATUS, 32'h5);
    cyc(2);
    arst_n <= 1'b0;
    cyc(4);
    arst_n <= 1'b1;
    rd(OFS_MODE, 32'h0);
    rd(OFS_STATE, 32'h0);
    note("application mode");
    cyc(3);
    give_verdict();
  end
endmodule : tb
bind poc_relay poc_chk #(.RETARD(RETARD), .RST_MAX(RST_MAX)) u_chk (.clk, .arst_n, .bus,
  .rdata, .meas, .tick, .di, .vi, .lgc, .relay, .led, .start, .trip, .status);

// ---- hw/poc_pkg.sv ----
package poc_pkg;
  localparam int NSTG = 6;
  localparam int NRLY = 8;
  localparam int NLED = 8;
  localparam int NSIG = 2 * NSTG;
  localparam int CLK_KHZ = 250000;
  localparam int RETARD_MS = 50;
  localparam int RESET_MAX_MS = 95;
  localparam int RETARD_CYC = RETARD_MS * CLK_KHZ;
  localparam int RESET_MAX_CYC = RESET_MAX_MS * CLK_KHZ;
  localparam logic [21:0] SAT_X = 22'h00_0032;
  localparam int STG_UF = 3;
  localparam int STG_NEG = 4;
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_KEY = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_INOM_F = 8'h0C;
  localparam logic [7:0] OFS_INOM_M = 8'h10;
  localparam logic [7:0] OFS_CTRL = 8'h14;
  localparam logic [7:0] OFS_LCLR = 8'h18;
  localparam logic [7:0] OFS_SET = 8'h20;
  localparam logic [7:0] OFS_AUX = 8'h40;
  localparam logic [7:0] OFS_BLK = 8'h60;
  localparam logic [7:0] OFS_RLY = 8'h80;
  localparam logic [7:0] OFS_LED = 8'hA0;
  localparam logic [7:0] OFS_STATE = 8'hC0;
  localparam logic [7:0] OFS_UV = 8'hC4;
  localparam int ST_MODE_BIT = 0;
  localparam int ST_UNLOCK_BIT = 1;
  localparam int ST_REJECT_BIT = 2;
  localparam int CTRL_LATCH_LSB = 8;
  localparam int CTRL_INV_BIT = 16;
  localparam logic RST_MODE = 1'b0;
  localparam logic [15:0] RST_INOM = 16'h0100;
  localparam logic [31:0] RST_CTRL = 32'h0000_003F;
  localparam logic [31:0] RST_SET = 32'h0000_FFFF;
  localparam logic [15:0] RST_AUX = 16'h0A04;
  localparam logic [15:0] RST_UV = 16'h0000;
  localparam logic [31:0] CONFIGURATION_MENU_KEY = 32'h5A5A_0001;
  typedef enum logic [1:0] {
    STG_IDLE = 2'b00,
    STG_START = 2'b01,
    STG_TRIP = 2'b11,
    STG_BLOCKED = 2'b10
  } poc_stg_e_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } poc_bus_t;
  typedef struct packed {
    logic [15:0] il1;
    logic [15:0] il2;
    logic [15:0] il3;
    logic [15:0] i2;
    logic [15:0] volt;
    logic [15:0] freq;
  } poc_meas_t;
  typedef struct packed {
    poc_stg_e_t st;
    logic hit;
    logic big;
    logic [23:0] cnt;
    logic [7:0] rcnt;
    logic [31:0] rcyc;
    logic [31:0] age;
  } poc_stage_s_t;
endpackage : poc_pkg

// ---- hw/poc_relay.sv ----
`timescale 1ns/1ns
module poc_relay #(
  parameter int RETARD = poc_pkg::RETARD_CYC,
  parameter int RST_MAX = poc_pkg::RESET_MAX_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire poc_pkg::poc_bus_t bus,
  output logic [31:0] rdata,
  input wire poc_pkg::poc_meas_t meas,
  input wire logic tick,
  input wire logic [7:0] di,
  input wire logic [7:0] vi,
  input wire logic [3:0] lgc,
  output logic [poc_pkg::NRLY-1:0] relay,
  output logic [poc_pkg::NLED-1:0] led,
  output logic [poc_pkg::NSTG-1:0] start,
  output logic [poc_pkg::NSTG-1:0] trip,
  output poc_pkg::poc_stg_e_t [poc_pkg::NSTG-1:0] status
);
  import poc_pkg::*;

  typedef struct packed {
    logic mode;
    logic unlock;
    logic reject;
    logic lclr;
    logic [15:0] inom_f;
    logic [15:0] inom_m;
    logic [31:0] ctrl;
    logic [NSTG-1:0][31:0] set;
    logic [NSTG-1:0][15:0] aux;
    logic [NSTG-1:0][31:0] blkm;
    logic [NRLY-1:0][NSIG-1:0] rmask;
    logic [NLED-1:0][NSIG-1:0] lmask;
    logic [15:0] uv;
    logic [NRLY-1:0] relay;
    logic [NLED-1:0] led;
    logic [31:0] rdata;
  } poc_top_s_t;

  poc_top_s_t s;
  poc_top_s_t next_s;
  logic [NSIG-1:0] sig;
  logic [31:0] blk_src;
  logic [15:0] ia;
  logic [15:0] ib;
  logic [15:0] ic;
  logic [15:0] imax;
  logic [15:0] inom_mode;
  logic uv_low;
  logic [NSTG-1:0][15:0] m_v;
  logic [NSTG-1:0][15:0] nom_v;
  logic [NSTG-1:0][15:0] thr_v;
  logic [NSTG-1:0] blk_v;
  logic [NSTG-1:0] en_v;
  logic [31:0] state_word;

  function automatic logic [15:0] scale_set(input logic [15:0] set, input logic [15:0] nom);
    logic [31:0] p;
    p = {16'h0000, set} * {16'h0000, nom};
    scale_set = (|p[31:24]) ? 16'hFFFF : p[23:8];
  endfunction : scale_set

  function automatic logic [15:0] sat_phase(input logic [15:0] x, input logic [15:0] nom);
    logic [21:0] lim;
    lim = {6'h00, nom} * SAT_X;
    sat_phase = ({6'h00, x} > lim) ? lim[15:0] : x;
  endfunction : sat_phase

  assign ia = sat_phase(meas.il1, inom_mode);
  assign ib = sat_phase(meas.il2, inom_mode);
  assign ic = sat_phase(meas.il3, inom_mode);
  assign imax = (ia > ib) ? ((ia > ic) ? ia : ic) : ((ib > ic) ? ib : ic);
  assign inom_mode = s.mode ? s.inom_m : s.inom_f;
  assign uv_low = meas.volt < s.uv;
  assign sig = {trip, start};
  assign blk_src = {trip, start, lgc, vi, di};

  for (genvar g = 0; g < NSTG; g++) begin : g_stg
    if (g < STG_UF) begin : g_oc
      assign m_v[g] = imax;
      assign nom_v[g] = inom_mode;
      assign en_v[g] = s.ctrl[g];
    end else if (g == STG_UF) begin : g_uf
      assign m_v[g] = meas.freq;
      assign nom_v[g] = 16'h0000;
      assign en_v[g] = s.ctrl[g];
    end else begin : g_mot
      assign m_v[g] = (g == STG_NEG) ? meas.i2 : imax;
      assign nom_v[g] = s.inom_m;
      assign en_v[g] = s.ctrl[g] & s.mode;
    end
    assign thr_v[g] = (g == STG_UF) ? s.set[g][15:0] : scale_set(s.set[g][15:0], nom_v[g]);
    assign blk_v[g] = (|(s.blkm[g] & blk_src)) | ((g == STG_UF) & uv_low);

    poc_stage #(
      .RETARD(RETARD),
      .RST_MAX(RST_MAX)
    ) u_stage (
      .clk(clk),
      .arst_n(arst_n),
      .tick(tick),
      .en(en_v[g]),
      .gt(g != STG_UF),
      .inv((g == 0) & s.ctrl[CTRL_INV_BIT]),
      .latch(s.ctrl[CTRL_LATCH_LSB + g]),
      .lclr(s.lclr),
      .blk(blk_v[g]),
      .meas(m_v[g]),
      .thr(thr_v[g]),
      .hyst(s.aux[g][7:0]),
      .dly(s.set[g][31:16]),
      .rdly(s.aux[g][15:8]),
      .start(start[g]),
      .trip(trip[g]),
      .status(status[g])
    );
  end

  always_comb begin
    state_word = 32'h0000_0000;
    for (int i = 0; i < NSTG; i++) begin
      state_word[2*i +: 2] = status[i];
    end
  end

  always_comb begin
    next_s = s;
    next_s.lclr = 1'b0;
    next_s.rdata = 32'h0000_0000;
    for (int r = 0; r < NRLY; r++) begin
      next_s.relay[r] = |(s.rmask[r] & sig);
    end
    for (int l = 0; l < NLED; l++) begin
      next_s.led[l] = |(s.lmask[l] & sig);
    end
    if (bus.wr) begin
      case (bus.addr)
        OFS_KEY: next_s.unlock = (bus.wdata == CONFIGURATION_MENU_KEY);
        OFS_MODE: begin
          if (s.unlock) begin
            next_s.mode = bus.wdata[0];
            next_s.unlock = 1'b0;
          end else begin
            next_s.reject = 1'b1;
          end
        end
        OFS_STATUS: begin
          if (bus.wdata[ST_REJECT_BIT]) begin
            next_s.reject = 1'b0;
          end
        end
        OFS_INOM_F: next_s.inom_f = bus.wdata[15:0];
        OFS_INOM_M: next_s.inom_m = bus.wdata[15:0];
        OFS_CTRL: next_s.ctrl = bus.wdata;
        OFS_LCLR: next_s.lclr = 1'b1;
        OFS_UV: next_s.uv = bus.wdata[15:0];
        default: ;
      endcase
      for (int i = 0; i < NSTG; i++) begin
        if (bus.addr == OFS_SET + 8'(4 * i)) begin
          next_s.set[i] = bus.wdata;
        end
        if (bus.addr == OFS_AUX + 8'(4 * i)) begin
          next_s.aux[i] = bus.wdata[15:0];
        end
        if (bus.addr == OFS_BLK + 8'(4 * i)) begin
          next_s.blkm[i] = bus.wdata;
        end
      end
      for (int r = 0; r < NRLY; r++) begin
        if (bus.addr == OFS_RLY + 8'(4 * r)) begin
          next_s.rmask[r] = bus.wdata[NSIG-1:0];
        end
      end
      for (int l = 0; l < NLED; l++) begin
        if (bus.addr == OFS_LED + 8'(4 * l)) begin
          next_s.lmask[l] = bus.wdata[NSIG-1:0];
        end
      end
    end
    if (bus.rd) begin
      case (bus.addr)
        OFS_MODE: next_s.rdata = {31'h0000_0000, s.mode};
        OFS_STATUS: next_s.rdata = {29'h0000_0000, s.reject, s.unlock, s.mode};
        OFS_INOM_F: next_s.rdata = {16'h0000, s.inom_f};
        OFS_INOM_M: next_s.rdata = {16'h0000, s.inom_m};
        OFS_CTRL: next_s.rdata = s.ctrl;
        OFS_STATE: next_s.rdata = state_word;
        OFS_UV: next_s.rdata = {16'h0000, s.uv};
        default: next_s.rdata = 32'h0000_0000;
      endcase
      for (int i = 0; i < NSTG; i++) begin
        if (bus.addr == OFS_SET + 8'(4 * i)) begin
          next_s.rdata = s.set[i];
        end
        if (bus.addr == OFS_AUX + 8'(4 * i)) begin
          next_s.rdata = {16'h0000, s.aux[i]};
        end
        if (bus.addr == OFS_BLK + 8'(4 * i)) begin
          next_s.rdata = s.blkm[i];
        end
      end
      for (int r = 0; r < NRLY; r++) begin
        if (bus.addr == OFS_RLY + 8'(4 * r)) begin
          next_s.rdata = {20'h0_0000, s.rmask[r]};
        end
      end
      for (int l = 0; l < NLED; l++) begin
        if (bus.addr == OFS_LED + 8'(4 * l)) begin
          next_s.rdata = {20'h0_0000, s.lmask[l]};
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s.mode <= RST_MODE;
      s.unlock <= 1'b0;
      s.reject <= 1'b0;
      s.lclr <= 1'b0;
      s.inom_f <= RST_INOM;
      s.inom_m <= RST_INOM;
      s.ctrl <= RST_CTRL;
      s.set <= {NSTG{RST_SET}};
      s.aux <= {NSTG{RST_AUX}};
      s.blkm <= '0;
      s.rmask <= '0;
      s.lmask <= '0;
      s.uv <= RST_UV;
      s.relay <= '0;
      s.led <= '0;
      s.rdata <= 32'h0000_0000;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign relay = s.relay;
  assign led = s.led;
endmodule : poc_relay

// ---- hw/poc_stage.sv ----
`timescale 1ns/1ns
module poc_stage #(
  parameter int RETARD = poc_pkg::RETARD_CYC,
  parameter int RST_MAX = poc_pkg::RESET_MAX_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic en,
  input wire logic gt,
  input wire logic inv,
  input wire logic latch,
  input wire logic lclr,
  input wire logic blk,
  input wire logic [15:0] meas,
  input wire logic [15:0] thr,
  input wire logic [7:0] hyst,
  input wire logic [15:0] dly,
  input wire logic [7:0] rdly,
  output logic start,
  output logic trip,
  output poc_pkg::poc_stg_e_t status
);
  import poc_pkg::*;
  poc_stage_s_t s;
  poc_stage_s_t next_s;
  logic [16:0] m17;
  logic [16:0] t17;
  logic [16:0] h17;
  logic [24:0] sum;
  logic [24:0] target;
  logic [24:0] step;
  logic rel_done;

  assign m17 = {1'b0, meas};
  assign t17 = {1'b0, thr};
  assign h17 = {9'h000, hyst};
  assign target = inv ? {1'b0, dly, 8'h00} : {9'h000, dly};
  assign step = (inv && meas > thr) ? {9'h000, meas - thr} : 25'h000_0001;
  assign sum = {1'b0, s.cnt} + step;
  assign rel_done = ({1'b0, s.rcnt} >= {1'b0, rdly} + {8'h00, s.big}) ||
    (s.rcyc >= 32'(RST_MAX));

  always_comb begin
    next_s = s;
    if (tick) begin
      next_s.age = 32'h0000_0000;
    end else if (s.age < 32'(RETARD)) begin
      next_s.age = s.age + 32'h0000_0001;
    end
    if (!en || s.age >= 32'(RETARD)) begin
      next_s.hit = 1'b0;
    end else if (tick && gt) begin
      if (m17 > t17) begin
        next_s.hit = 1'b1;
      end else if (m17 + h17 < t17) begin
        next_s.hit = 1'b0;
      end
      if (m17 > {t17[15:0], 1'b0}) begin
        next_s.big = s.hit;
      end
    end else if (tick) begin
      if (m17 < t17) begin
        next_s.hit = 1'b1;
      end else if (m17 > t17 + h17) begin
        next_s.hit = 1'b0;
      end
    end
    if (s.hit) begin
      next_s.rcnt = 8'h00;
      next_s.rcyc = 32'h0000_0000;
    end else begin
      next_s.rcyc = s.rcyc + 32'h0000_0001;
      if (tick) begin
        next_s.rcnt = s.rcnt + 8'h01;
      end
    end
    case (s.st)
      STG_IDLE: begin
        next_s.cnt = 24'h00_0000;
        next_s.big = 1'b0;
        if (s.hit) begin
          if (blk) begin
            next_s.st = STG_BLOCKED;
          end else if (!inv && dly == 16'h0000) begin
            next_s.st = STG_TRIP;
          end else begin
            next_s.st = STG_START;
          end
        end
      end
      STG_BLOCKED: begin
        if (!s.hit) begin
          next_s.st = STG_IDLE;
          next_s.cnt = 24'h00_0000;
        end else if (!blk) begin
          next_s.st = STG_START;
        end
      end
      STG_START: begin
        if (!s.hit) begin
          next_s.cnt = 24'h00_0000;
          if (rel_done) begin
            next_s.st = STG_IDLE;
          end
        end else if (blk) begin
          next_s.st = STG_BLOCKED;
        end else if (tick) begin
          if (sum >= target) begin
            next_s.st = STG_TRIP;
          end else begin
            next_s.cnt = sum[23:0];
          end
        end
      end
      STG_TRIP: begin
        if (!s.hit && latch) begin
          if (lclr) begin
            next_s.st = STG_IDLE;
          end
        end else if (!s.hit && rel_done) begin
          next_s.st = STG_IDLE;
        end
      end
      default: next_s.st = STG_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '{st: STG_IDLE, hit: 1'b0, big: 1'b0, cnt: 24'h00_0000, rcnt: 8'h00,
        rcyc: 32'h0000_0000, age: 32'h0000_0000};
    end else begin
      s <= next_s;
    end
  end

  assign start = (s.st == STG_START) || (s.st == STG_TRIP);
  assign trip = (s.st == STG_TRIP);
  assign status = s.st;
endmodule : poc_stage
